// ### card_protocol_clock_config.sv
// card protocol and clock configuration bank with sync-mode pin routing,
// card clock divider and check-code unit
// assumes an APB master on I_CLK and a UART datapath on the same clock
//
// Decided for this implementation: the APB register port.

// Contract
// - C8 contact is input when its direction bit is 1, output when 0.
// - C4 contact is input when its direction bit is 1, output when 0.
// - Direction register resets to zero; C4 and C8 stay tri-stated after reset.
// - Internal sync routes RST, IO, C4, C8 to control bits; clock from ETU.
// - External sync routes data pin to control bits; clock from ETU counter.
// - Nine-bit sync words: eight bits to receive path, ninth to receive control.
// - Protocol select 0 means T=0, 1 means T=1.
// - Check-code enable acts only in T=1; ignored in T=0.
// - Enabled check code is appended after the last transmit byte.
// - Enabled check code of received bytes is readable in low/high registers.
// - Check type 1 selects CRC, 0 selects LRC.
// - ATR timeout enabled while its bit is 1; reset sets it at power-on.
// - Master clock divided by value plus one for ETU, then two for card clock.
// - Divider field resets to 0x0C, ratio 13.
// - New divider value takes effect without glitching the card clock.
// - Divider value 0 behaves as 1.
// - Protocol register resets to 0x03.
// - Output contact drives its control bit; read returns the stored bit.
// - In external sync mode external data bit holds pin value at latest clock rise.
module card_protocol_clock_config
  import card_cfg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [APB_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_C4,
  input wire logic I_C8,
  input wire logic I_IO,
  input wire logic I_SIO,
  input wire logic I_UART_RST,
  input wire logic I_UART_IO,
  input wire logic I_UART_IO_OE,
  input wire logic I_UART_SIO,
  input wire logic I_UART_SIO_OE,
  input wire logic I_EXT_CLK_SRC,
  input wire logic [7:0] I_TX_BYTE,
  input wire logic I_TX_STB,
  input wire logic I_TX_LAST,
  input wire logic [7:0] I_RX_BYTE,
  input wire logic I_RX_STB,
  input wire logic I_RX_START,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_C4,
  output logic O_C4_OE,
  output logic O_C8,
  output logic O_C8_OE,
  output logic O_RST,
  output logic O_IO,
  output logic O_IO_OE,
  output logic O_SIO,
  output logic O_SIO_OE,
  output logic O_CARD_CLK,
  output logic O_EXT_CLK,
  output logic O_ETU_TICK,
  output logic O_T1_MODE,
  output logic O_CHECK_ACTIVE,
  output logic O_CRC_MODE,
  output logic O_ATR_TIMEOUT_EN,
  output logic [7:0] O_RX_WORD,
  output logic O_RX_WORD_STB,
  output logic [7:0] O_CHK_BYTE,
  output logic O_CHK_STB
);

  function automatic logic [DIV_W-1:0] div_eff(input logic [7:0] v);
    div_eff = (v[DIV_W-1:0] == '0) ? DIV_MIN : v[DIV_W-1:0];
  endfunction : div_eff

  function automatic logic [15:0] chk_init(input logic crc);
    chk_init = crc ? CRC_INIT : LRC_INIT;
  endfunction : chk_init

  function automatic logic [15:0] chk_update(input logic [15:0] c, input logic [7:0] d,
                                             input logic crc);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++) begin
      x = x[15] ? ({x[14:0], 1'b0} ^ CRC_POLY) : {x[14:0], 1'b0};
    end
    chk_update = crc ? x : {8'h00, c[7:0] ^ d};
  endfunction : chk_update

  // pin synchronisers
  logic [3:0] pin_meta_r;
  logic [3:0] pin_s_r;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_meta_r <= 4'h0;
      pin_s_r <= 4'h0;
    end else begin
      pin_meta_r <= {I_SIO, I_IO, I_C8, I_C4};
      pin_s_r <= pin_meta_r;
    end
  end

  // register file and APB slave
  logic [7:0] card_ctl_r, card_ctl_nxt;
  logic [7:0] ext_ctl_r, ext_ctl_nxt;
  logic [7:0] aux_dir_r, aux_dir_nxt;
  proto_mode_type proto_r, proto_nxt;
  logic [7:0] clk_div_r, clk_div_nxt;
  logic armed_r, armed_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [15:0] idx;
  logic acc;
  logic wr_en;
  logic hit;
  logic [7:0] rd_val;
  logic ninth_r;
  logic sio_smp_r;
  logic [15:0] rx_chk_r;
  logic check_on;
  logic check_on_r;

  always_comb begin
    idx = I_PADDR[APB_ADDR_W-1:2];
    acc = I_PSEL & I_PENABLE & ~pready_r;
    wr_en = I_PSEL & I_PENABLE & pready_r & I_PWRITE;
    hit = 1'b1;
    rd_val = 8'h00;
    if (idx == IDX_CARD_CTL) begin
      rd_val = card_ctl_r;
      // inputs read the pin, outputs the stored bit
      if (card_ctl_r[CTL_IO_DIR_BIT]) rd_val[CTL_IO_BIT] = pin_s_r[PIN_IO];
      if (aux_dir_r[AUX_C8_DIR_BIT]) rd_val[CTL_C8_BIT] = pin_s_r[PIN_C8];
      if (aux_dir_r[AUX_C4_DIR_BIT]) rd_val[CTL_C4_BIT] = pin_s_r[PIN_C4];
    end else if (idx == IDX_EXT_CTL) begin
      rd_val = ext_ctl_r;
      if (proto_r.external_sync_enable) rd_val[EXT_SIO_BIT] = sio_smp_r;
      else if (ext_ctl_r[EXT_SIO_DIR_BIT]) rd_val[EXT_SIO_BIT] = pin_s_r[PIN_SIO];
    end else if (idx == IDX_AUX_DIR) begin
      rd_val = aux_dir_r;
    end else if (idx == IDX_PROTO) begin
      rd_val = proto_r;
    end else if (idx == IDX_CLK_DIV) begin
      rd_val = clk_div_r;
    end else if (idx == IDX_RX_CTL) begin
      rd_val[RX_NINTH_BIT] = ninth_r;
    end else if (idx == IDX_CHK_LO) begin
      rd_val = rx_chk_r[7:0];
    end else if (idx == IDX_CHK_HI) begin
      rd_val = rx_chk_r[15:8];
    end else begin
      hit = 1'b0;
    end
    pready_nxt = acc;
    pslverr_nxt = acc & ~hit;
    prdata_nxt = acc ? {24'h000000, rd_val} : prdata_r;
    card_ctl_nxt = card_ctl_r;
    ext_ctl_nxt = ext_ctl_r;
    aux_dir_nxt = aux_dir_r;
    proto_nxt = proto_r;
    clk_div_nxt = clk_div_r;
    armed_nxt = armed_r;
    if (wr_en) begin
      if (idx == IDX_CARD_CTL) begin
        card_ctl_nxt = I_PWDATA[7:0] & MASK_CARD_CTL;
      end else if (idx == IDX_EXT_CTL) begin
        ext_ctl_nxt = I_PWDATA[7:0] & MASK_EXT_CTL;
      end else if (idx == IDX_AUX_DIR) begin
        aux_dir_nxt = I_PWDATA[7:0] & MASK_AUX_DIR;
        armed_nxt = 1'b1;
      end else if (idx == IDX_PROTO) begin
        proto_nxt = proto_mode_type'(I_PWDATA[7:0] & MASK_PROTO);
      end else if (idx == IDX_CLK_DIV) begin
        clk_div_nxt = I_PWDATA[7:0] & MASK_CLK_DIV;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      card_ctl_r <= RST_CARD_CTL;
      ext_ctl_r <= RST_EXT_CTL;
      aux_dir_r <= RST_AUX_DIR;
      proto_r <= proto_mode_type'(RST_PROTO);
      clk_div_r <= RST_CLK_DIV;
      armed_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      card_ctl_r <= card_ctl_nxt;
      ext_ctl_r <= ext_ctl_nxt;
      aux_dir_r <= aux_dir_nxt;
      proto_r <= proto_nxt;
      clk_div_r <= clk_div_nxt;
      armed_r <= armed_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ETU prescaler and card clock; the period changes only at a wrap
  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic cclk_r, cclk_nxt;
  logic tick_r, tick_nxt;
  logic rise;

  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    div_nxt = div_r;
    cclk_nxt = cclk_r;
    tick_nxt = 1'b0;
    rise = 1'b0;
    if (cnt_r >= div_r) begin
      cnt_nxt = '0;
      div_nxt = div_eff(clk_div_r);
      cclk_nxt = ~cclk_r;
      tick_nxt = 1'b1;
      rise = ~cclk_r;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_r <= '0;
      div_r <= RST_CLK_DIV[DIV_W-1:0];
      cclk_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      cclk_r <= cclk_nxt;
      tick_r <= tick_nxt;
    end
  end

  // synchronous-mode word receiver, sampled on card clock rising edges
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic ninth_nxt;
  logic sio_smp_nxt;
  byte_evt_type rx_evt_r, rx_evt_nxt;
  logic rx_on;
  logic rx_bit;

  always_comb begin
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    ninth_nxt = ninth_r;
    sio_smp_nxt = sio_smp_r;
    rx_evt_nxt = '{data: rx_evt_r.data, stb: 1'b0};
    rx_on = proto_r.internal_sync_enable | proto_r.external_sync_enable;
    rx_bit = proto_r.internal_sync_enable ? pin_s_r[PIN_IO] : pin_s_r[PIN_SIO];
    if (proto_r.external_sync_enable && rise) sio_smp_nxt = pin_s_r[PIN_SIO];
    if (!rx_on) begin
      bitcnt_nxt = 4'h0;
    end else if (rise) begin
      if (bitcnt_r == WORD_LAST9) begin
        ninth_nxt = rx_bit;
        bitcnt_nxt = 4'h0;
      end else begin
        shift_nxt = {rx_bit, shift_r[7:1]};
        bitcnt_nxt = bitcnt_r + 4'h1;
        if (bitcnt_r == WORD_LAST8) begin
          rx_evt_nxt = '{data: {rx_bit, shift_r[7:1]}, stb: 1'b1};
          if (!proto_r.nine_bit_select) bitcnt_nxt = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      ninth_r <= 1'b0;
      sio_smp_r <= 1'b0;
      rx_evt_r <= '0;
    end else begin
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      ninth_r <= ninth_nxt;
      sio_smp_r <= sio_smp_nxt;
      rx_evt_r <= rx_evt_nxt;
    end
  end

  // check-code unit: receive accumulation and transmit append
  logic [15:0] rx_chk_nxt;
  logic [15:0] tx_chk_r, tx_chk_nxt;
  tx_state_type tx_st_r, tx_st_nxt;
  byte_evt_type chk_evt_r, chk_evt_nxt;

  always_comb begin
    check_on = proto_r.protocol_select & proto_r.check_code_enable;
    rx_chk_nxt = rx_chk_r;
    tx_chk_nxt = tx_chk_r;
    tx_st_nxt = tx_st_r;
    chk_evt_nxt = '{data: chk_evt_r.data, stb: 1'b0};
    if (wr_en && idx == IDX_PROTO) tx_chk_nxt = chk_init(proto_nxt.check_type_select);
    if (I_RX_START) begin
      rx_chk_nxt = chk_init(proto_r.check_type_select);
    end else if (I_RX_STB && check_on) begin
      rx_chk_nxt = chk_update(rx_chk_r, I_RX_BYTE, proto_r.check_type_select);
    end
    case (tx_st_r)
      TX_IDLE: begin
        if (I_TX_STB && check_on) begin
          tx_chk_nxt = chk_update(tx_chk_r, I_TX_BYTE, proto_r.check_type_select);
          if (I_TX_LAST) tx_st_nxt = proto_r.check_type_select ? TX_HI : TX_LO;
        end
      end
      TX_HI: begin
        chk_evt_nxt = '{data: tx_chk_r[15:8], stb: 1'b1};
        tx_st_nxt = TX_LO;
      end
      TX_LO: begin
        chk_evt_nxt = '{data: tx_chk_r[7:0], stb: 1'b1};
        tx_chk_nxt = chk_init(proto_r.check_type_select);
        tx_st_nxt = TX_IDLE;
      end
      default: begin
        tx_st_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_chk_r <= CRC_INIT;
      tx_chk_r <= CRC_INIT;
      tx_st_r <= TX_IDLE;
      chk_evt_r <= '0;
    end else begin
      rx_chk_r <= rx_chk_nxt;
      tx_chk_r <= tx_chk_nxt;
      tx_st_r <= tx_st_nxt;
      chk_evt_r <= chk_evt_nxt;
    end
  end

  // contact drivers and mode outputs
  logic c4_r, c4_nxt, c4_oe_r, c4_oe_nxt;
  logic c8_r, c8_nxt, c8_oe_r, c8_oe_nxt;
  logic rst_r, rst_nxt;
  logic io_r, io_nxt, io_oe_r, io_oe_nxt;
  logic sio_r, sio_nxt, sio_oe_r, sio_oe_nxt;
  logic eclk_r, eclk_nxt;

  always_comb begin
    c8_nxt = card_ctl_r[CTL_C8_BIT];
    c8_oe_nxt = armed_r & ~aux_dir_r[AUX_C8_DIR_BIT];
    c4_nxt = card_ctl_r[CTL_C4_BIT];
    c4_oe_nxt = armed_r & ~aux_dir_r[AUX_C4_DIR_BIT];
    if (proto_r.internal_sync_enable) begin
      rst_nxt = card_ctl_r[CTL_RST_BIT];
      io_nxt = card_ctl_r[CTL_IO_BIT];
      io_oe_nxt = ~card_ctl_r[CTL_IO_DIR_BIT];
    end else begin
      rst_nxt = I_UART_RST;
      io_nxt = I_UART_IO;
      io_oe_nxt = I_UART_IO_OE;
    end
    if (proto_r.external_sync_enable) begin
      sio_nxt = ext_ctl_r[EXT_SIO_BIT];
      sio_oe_nxt = ~ext_ctl_r[EXT_SIO_DIR_BIT];
      eclk_nxt = cclk_nxt;
    end else begin
      sio_nxt = I_UART_SIO;
      sio_oe_nxt = I_UART_SIO_OE;
      eclk_nxt = I_EXT_CLK_SRC;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      c4_r <= 1'b0;
      c4_oe_r <= 1'b0;
      c8_r <= 1'b0;
      c8_oe_r <= 1'b0;
      rst_r <= 1'b0;
      io_r <= 1'b0;
      io_oe_r <= 1'b0;
      sio_r <= 1'b0;
      sio_oe_r <= 1'b0;
      eclk_r <= 1'b0;
    end else begin
      c4_r <= c4_nxt;
      c4_oe_r <= c4_oe_nxt;
      c8_r <= c8_nxt;
      c8_oe_r <= c8_oe_nxt;
      rst_r <= rst_nxt;
      io_r <= io_nxt;
      io_oe_r <= io_oe_nxt;
      sio_r <= sio_nxt;
      sio_oe_r <= sio_oe_nxt;
      eclk_r <= eclk_nxt;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_C4 = c4_r;
  assign O_C4_OE = c4_oe_r;
  assign O_C8 = c8_r;
  assign O_C8_OE = c8_oe_r;
  assign O_RST = rst_r;
  assign O_IO = io_r;
  assign O_IO_OE = io_oe_r;
  assign O_SIO = sio_r;
  assign O_SIO_OE = sio_oe_r;
  assign O_CARD_CLK = cclk_r;
  assign O_EXT_CLK = eclk_r;
  assign O_ETU_TICK = tick_r;
  assign O_T1_MODE = proto_r.protocol_select;
  assign O_CHECK_ACTIVE = check_on_r;
  assign O_CRC_MODE = proto_r.check_type_select;
  assign O_ATR_TIMEOUT_EN = proto_r.atr_timeout_enable;
  assign O_RX_WORD = rx_evt_r.data;
  assign O_RX_WORD_STB = rx_evt_r.stb;
  assign O_CHK_BYTE = chk_evt_r.data;
  assign O_CHK_STB = chk_evt_r.stb;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      check_on_r <= 1'b0;
    end else begin
      check_on_r <= check_on;
    end
  end

endmodule : card_protocol_clock_config

// ### card_cfg_pkg.sv
// register map, field layout, reset values and shared types of the card
// protocol and clock configuration bank; assumes a 32-bit APB register bus
package card_cfg_pkg;

  localparam int APB_ADDR_W = 18;
  localparam int DIV_W = 6;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CARD_CTL = 16'hFE0A;
  localparam logic [15:0] IDX_EXT_CTL = 16'hFE0B;
  localparam logic [15:0] IDX_AUX_DIR = 16'hFE0C;
  localparam logic [15:0] IDX_PROTO = 16'hFE0D;
  localparam logic [15:0] IDX_CLK_DIV = 16'hFE0F;
  localparam logic [15:0] IDX_RX_CTL = 16'hFE20;
  localparam logic [15:0] IDX_CHK_LO = 16'hFE21;
  localparam logic [15:0] IDX_CHK_HI = 16'hFE22;

  // values after reset
  localparam logic [7:0] RST_CARD_CTL = 8'h10;
  localparam logic [7:0] RST_EXT_CTL = 8'h00;
  localparam logic [7:0] RST_AUX_DIR = 8'h00;
  localparam logic [7:0] RST_PROTO = 8'h03;
  localparam logic [7:0] RST_CLK_DIV = 8'h0C;

  // writable bits; all others read as zero
  localparam logic [7:0] MASK_CARD_CTL = 8'hBC;
  localparam logic [7:0] MASK_EXT_CTL = 8'h30;
  localparam logic [7:0] MASK_AUX_DIR = 8'h0C;
  localparam logic [7:0] MASK_PROTO = 8'hEF;
  localparam logic [7:0] MASK_CLK_DIV = 8'h3F;

  // field positions
  localparam int AUX_C8_DIR_BIT = 3;
  localparam int AUX_C4_DIR_BIT = 2;
  localparam int CTL_RST_BIT = 7;
  localparam int CTL_IO_BIT = 5;
  localparam int CTL_IO_DIR_BIT = 4;
  localparam int CTL_C8_BIT = 3;
  localparam int CTL_C4_BIT = 2;
  localparam int EXT_SIO_BIT = 5;
  localparam int EXT_SIO_DIR_BIT = 4;
  localparam int RX_NINTH_BIT = 0;

  // synchronised pin vector positions
  localparam int PIN_C4 = 0;
  localparam int PIN_C8 = 1;
  localparam int PIN_IO = 2;
  localparam int PIN_SIO = 3;

  localparam logic [DIV_W-1:0] DIV_MIN = 6'h01;
  localparam logic [3:0] WORD_LAST8 = 4'h7;
  localparam logic [3:0] WORD_LAST9 = 4'h8;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] LRC_INIT = 16'h0000;

  typedef struct packed {
    logic internal_sync_enable;
    logic nine_bit_select;
    logic external_sync_enable;
    logic reserved;
    logic protocol_select;
    logic check_code_enable;
    logic check_type_select;
    logic atr_timeout_enable;
  } proto_mode_type;

  typedef struct packed {
    logic [7:0] data;
    logic stb;
  } byte_evt_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HI = 2'b01,
    TX_LO = 2'b10
  } tx_state_type;

endpackage : card_cfg_pkg

// ### card_cfg_asserts.sv
// concurrent checks of the card configuration bank at its top-level ports
// assumes one clock and an async active-low reset; bound below the module
module card_cfg_asserts
  import card_cfg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [APB_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_C4_OE,
  input wire logic O_C8_OE,
  input wire logic O_CARD_CLK,
  input wire logic O_ETU_TICK,
  input wire logic O_T1_MODE,
  input wire logic O_CHECK_ACTIVE,
  input wire logic O_CRC_MODE,
  input wire logic O_ATR_TIMEOUT_EN
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  logic wr_done;
  logic [15:0] idx;
  logic [6:0] eff;
  logic seen_r, seen_nxt;
  logic [5:0] div_r, div_nxt;
  logic [6:0] gap_r, gap_nxt;
  logic [1:0] nw_r, nw_nxt;
  assign wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign idx = I_PADDR[17:2];
  assign eff = (div_r == 6'h00) ? 7'h02 : {1'h0, div_r} + 7'h01;
  // track the programmed divisor and the spacing of ticks
  always_comb begin
    seen_nxt = seen_r || (wr_done && idx == IDX_AUX_DIR);
    div_nxt = (wr_done && idx == IDX_CLK_DIV) ? I_PWDATA[5:0] : div_r;
    gap_nxt = O_ETU_TICK ? 7'h01 : gap_r + 7'h01;
    nw_nxt = nw_r;
    if (wr_done && idx == IDX_CLK_DIV) nw_nxt = 2'h0;
    else if (O_ETU_TICK && nw_r != 2'h2) nw_nxt = nw_r + 2'h1;
  end
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      seen_r <= 1'h0;
      div_r <= 6'h0C;
      gap_r <= 7'h00;
      nw_r <= 2'h1;
    end else begin
      seen_r <= seen_nxt;
      div_r <= div_nxt;
      gap_r <= gap_nxt;
      nw_r <= nw_nxt;
    end
  end
  sequence s_setup;
    I_PSEL && !I_PENABLE ##1 I_PSEL && I_PENABLE;
  endsequence
  sequence s_wr(ix);
    wr_done && idx == ix;
  endsequence
  property p_one_wait;
    s_setup |-> !O_PREADY ##1 O_PREADY;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready not in second access cycle");
  property p_c8_in;
    s_wr(IDX_AUX_DIR) ##0 I_PWDATA[AUX_C8_DIR_BIT] |-> ##2 !O_C8_OE;
  endproperty
  a_c8_in: assert property (p_c8_in) else $error("c8 still driven");
  property p_c4_out;
    s_wr(IDX_AUX_DIR) ##0 !I_PWDATA[AUX_C4_DIR_BIT] |-> ##2 O_C4_OE;
  endproperty
  a_c4_out: assert property (p_c4_out) else $error("c4 not driven");
  property p_tristate;
    !seen_r |-> !O_C4_OE && !O_C8_OE;
  endproperty
  a_tristate: assert property (p_tristate) else $error("contact driven after reset");
  property p_proto;
    s_wr(IDX_PROTO) |=> O_T1_MODE == $past(I_PWDATA[3]) && O_CRC_MODE == $past(I_PWDATA[1]);
  endproperty
  a_proto: assert property (p_proto) else $error("mode outputs differ");
  property p_active;
    O_CHECK_ACTIVE |-> O_T1_MODE || $past(O_T1_MODE);
  endproperty
  a_active: assert property (p_active) else $error("check active outside t1");
  property p_proto_rst;
    $rose(I_RST_B) |-> ##[1:2] (O_CRC_MODE && O_ATR_TIMEOUT_EN && !O_T1_MODE);
  endproperty
  a_proto_rst: assert property (p_proto_rst) else $error("mode reset wrong");
  property p_tick;
    O_ETU_TICK && nw_r == 2'h2 |-> gap_r == eff;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_no_glitch;
    $changed(O_CARD_CLK) |=> $stable(O_CARD_CLK);
  endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("card clock glitch");
  property p_clk_tick;
    $changed(O_CARD_CLK) |-> O_ETU_TICK || $past(O_ETU_TICK);
  endproperty
  a_clk_tick: assert property (p_clk_tick) else $error("card clock off tick");
  property p_rdata;
    O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h000000 && (!O_PSLVERR || O_PRDATA == 32'h0);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read upper bits set");
endmodule : card_cfg_asserts

bind card_protocol_clock_config card_cfg_asserts u_chk (.I_CLK, .I_RST_B, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_C4_OE, .O_C8_OE,
  .O_CARD_CLK, .O_ETU_TICK, .O_T1_MODE, .O_CHECK_ACTIVE, .O_CRC_MODE, .O_ATR_TIMEOUT_EN);

// ### card_model.sv
// contact-side model of the internal card
// assumes reader enables are high while the reader drives; io has a pull-up
module card_model (
  input wire logic i_c4,
  input wire logic i_c4_oe,
  input wire logic i_c8,
  input wire logic i_c8_oe,
  input wire logic i_io,
  input wire logic i_io_oe,
  input wire logic i_lvl,
  output logic o_c4,
  output logic o_c8,
  output logic o_io
);
  timeunit 1ns;
  timeprecision 100ps;
  // card drives released c4 and c8 with its own level; released io is pulled up
  assign o_c4 = i_c4_oe ? i_c4 : i_lvl;
  assign o_c8 = i_c8_oe ? i_c8 : i_lvl;
  assign o_io = i_io_oe ? i_io : 1'h1;
endmodule : card_model

// ### card_protocol_clock_config_bench.sv
// self-checking bench of the card configuration bank
// assumes the card model on the contacts and an APB master driven here
module card_protocol_clock_config_bench import card_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CLK, I_RST_B, I_PSEL, I_PENABLE, I_PWRITE, card_lvl;
  logic [APB_ADDR_W-1:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA;
  logic I_C4, I_C8, I_IO, I_SIO, I_UART_RST, I_UART_IO, I_UART_IO_OE, I_UART_SIO, I_UART_SIO_OE;
  logic I_EXT_CLK_SRC, I_TX_STB, I_TX_LAST, I_RX_STB, I_RX_START;
  logic [7:0] I_TX_BYTE, I_RX_BYTE, O_RX_WORD, O_CHK_BYTE;
  logic O_PREADY, O_PSLVERR, O_C4, O_C4_OE, O_C8, O_C8_OE, O_RST, O_IO, O_IO_OE, O_SIO;
  logic O_SIO_OE, O_CARD_CLK, O_EXT_CLK, O_ETU_TICK, O_T1_MODE, O_CHECK_ACTIVE, O_CRC_MODE;
  logic O_ATR_TIMEOUT_EN, O_RX_WORD_STB, O_CHK_STB;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  card_protocol_clock_config u_dut (.I_CLK, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .I_C4, .I_C8, .I_IO, .I_SIO, .I_UART_RST, .I_UART_IO, .I_UART_IO_OE, .I_UART_SIO,
    .I_UART_SIO_OE, .I_EXT_CLK_SRC, .I_TX_BYTE, .I_TX_STB, .I_TX_LAST, .I_RX_BYTE, .I_RX_STB,
    .I_RX_START, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_C4, .O_C4_OE, .O_C8, .O_C8_OE, .O_RST,
    .O_IO, .O_IO_OE, .O_SIO, .O_SIO_OE, .O_CARD_CLK, .O_EXT_CLK, .O_ETU_TICK, .O_T1_MODE,
    .O_CHECK_ACTIVE, .O_CRC_MODE, .O_ATR_TIMEOUT_EN, .O_RX_WORD, .O_RX_WORD_STB, .O_CHK_BYTE,
    .O_CHK_STB);
  card_model u_card (.i_c4(O_C4), .i_c4_oe(O_C4_OE), .i_c8(O_C8), .i_c8_oe(O_C8_OE), .i_io(O_IO),
    .i_io_oe(O_IO_OE), .i_lvl(card_lvl), .o_c4(I_C4), .o_c8(I_C8), .o_io(I_IO));
  initial begin
    I_CLK = 1'h0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [15:0] ix, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    I_PSEL <= 1'h1;
    I_PWRITE <= wr;
    I_PADDR <= {ix, 2'h0};
    I_PWDATA <= {24'h000000, wd};
    @(posedge I_CLK);
    I_PENABLE <= 1'h1;
    do @(posedge I_CLK); while (O_PREADY !== 1'h1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'h0;
    I_PENABLE <= 1'h0;
    @(posedge I_CLK);
  endtask : apb
  task automatic wreg(input logic [15:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, ix, d, r, e);
  endtask : wreg
  task automatic rchk(input string name, input logic [15:0] ix, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, ix, 8'h00, r, e);
    chk(name, r, exp);
  endtask : rchk
  task automatic do_reset;
    I_RST_B <= 1'h0;
    repeat (16) @(posedge I_CLK);
    I_RST_B <= 1'h1;
  endtask : do_reset
  task automatic t_reset;
    chk("c4_oe", O_C4_OE, 1'h0);
    chk("c8_oe", O_C8_OE, 1'h0);
    rchk("aux_dir", IDX_AUX_DIR, 32'h00);
    rchk("proto", IDX_PROTO, 32'h03);
    rchk("clk_div", IDX_CLK_DIV, 32'h0C);
    chk("crc_mode", O_CRC_MODE, 1'h1);
    chk("atr_en", O_ATR_TIMEOUT_EN, 1'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_dir;
    logic [31:0] r;
    logic e;
    wreg(IDX_CARD_CTL, 8'h18);
    card_lvl <= 1'h0;
    wreg(IDX_AUX_DIR, 8'hFF);
    rchk("aux_dir_w", IDX_AUX_DIR, 32'h0C);
    chk("c8_oe_in", O_C8_OE, 1'h0);
    chk("c4_oe_in", O_C4_OE, 1'h0);
    rchk("ctl_pins", IDX_CARD_CTL, 32'h30);
    wreg(IDX_AUX_DIR, 8'h00);
    repeat (2) @(posedge I_CLK);
    chk("c8_oe_out", O_C8_OE, 1'h1);
    chk("c4_oe_out", O_C4_OE, 1'h1);
    chk("c8_val", O_C8, 1'h1);
    chk("c4_val", O_C4, 1'h0);
    rchk("ctl_stored", IDX_CARD_CTL, 32'h38);
    apb(1'h0, 16'h0000, 8'h00, r, e);
    chk("slverr", e, 1'h1);
    chk("unmapped", r, 32'h0);
    $display("test dir done");
  endtask : t_dir
  task automatic t_chk;
    logic [7:0] pv[3] = '{8'h0D, 8'h0E, 8'h07};
    int ns[3] = '{1, 2, 0};
    int n;
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      wreg(IDX_PROTO, pv[i]);
      rchk("proto_rd", IDX_PROTO, {24'h0, pv[i]});
      chk("t1", O_T1_MODE, pv[i][3]);
      chk("crc", O_CRC_MODE, pv[i][1]);
      chk("atr", O_ATR_TIMEOUT_EN, pv[i][0]);
      chk("active", O_CHECK_ACTIVE, pv[i][3]);
      I_TX_BYTE <= 8'hA5;
      I_TX_STB <= 1'h1;
      @(posedge I_CLK);
      I_TX_BYTE <= 8'h3C;
      I_TX_LAST <= 1'h1;
      @(posedge I_CLK);
      I_TX_STB <= 1'h0;
      I_TX_LAST <= 1'h0;
      n = 0;
      b = 8'h00;
      repeat (5) begin
        @(posedge I_CLK);
        if (O_CHK_STB === 1'h1) begin
          if (n == 0) b = O_CHK_BYTE;
          n++;
        end
      end
      chk("chk_count", n, ns[i]);
      if (i == 0) chk("lrc_tx", b, 8'h99);
    end
    wreg(IDX_PROTO, 8'h0D);
    I_RX_START <= 1'h1;
    @(posedge I_CLK);
    I_RX_START <= 1'h0;
    I_RX_BYTE <= 8'h12;
    I_RX_STB <= 1'h1;
    @(posedge I_CLK);
    I_RX_BYTE <= 8'h34;
    @(posedge I_CLK);
    I_RX_STB <= 1'h0;
    rchk("lrc_rx", IDX_CHK_LO, 32'h26);
    $display("test check code done");
  endtask : t_chk
  task automatic t_sync;
    wreg(IDX_PROTO, 8'hA0);
    wreg(IDX_CARD_CTL, 8'hA0);
    wreg(IDX_EXT_CTL, 8'h20);
    repeat (2) @(posedge I_CLK);
    chk("rst_sync", O_RST, 1'h1);
    chk("io_sync", {O_IO_OE, O_IO}, 2'h3);
    chk("sio_sync", {O_SIO_OE, O_SIO}, 2'h3);
    repeat (260) if (O_RX_WORD_STB !== 1'h1) @(posedge I_CLK);
    chk("rx_word", {O_RX_WORD_STB, O_RX_WORD}, 9'h1FF);
    wreg(IDX_PROTO, 8'h03);
    I_UART_RST <= 1'h0;
    I_EXT_CLK_SRC <= 1'h1;
    repeat (3) @(posedge I_CLK);
    chk("rst_uart", O_RST, 1'h0);
    chk("ext_clk", O_EXT_CLK, 1'h1);
    $display("test sync done");
  endtask : t_sync
  function automatic logic pick(input logic sel);
    return sel ? O_CARD_CLK : O_ETU_TICK;
  endfunction : pick
  // tick: count of cycles between ticks less one; clock: low phase length
  task automatic meas(input logic sel, output int p);
    int n = 0;
    p = 0;
    while (pick(sel) !== 1'h1 && n < 200) begin
      @(posedge I_CLK);
      n++;
    end
    while (pick(sel) !== 1'h0 && n < 200) begin
      @(posedge I_CLK);
      n++;
    end
    while (pick(sel) !== 1'h1 && n < 400) begin
      @(posedge I_CLK);
      n++;
      p++;
    end
  endtask : meas
  task automatic t_div;
    logic [5:0] dv[3] = '{6'h00, 6'h03, 6'h0C};
    int p;
    int e;
    for (int i = 0; i < 3; i++) begin
      wreg(IDX_CLK_DIV, {2'h0, dv[i]});
      e = (dv[i] == 6'h00) ? 1 : int'(dv[i]);
      meas(1'h0, p);
      meas(1'h0, p);
      chk("etu_period", p, e);
      meas(1'h1, p);
      chk("card_clk_low", p, e + 1);
    end
    $display("test divider done");
  endtask : t_div
  initial begin
    I_RST_B = 1'h0;
    {I_PSEL, I_PENABLE, I_PWRITE, I_TX_STB, I_TX_LAST, I_RX_STB, I_RX_START} = 7'h00;
    I_PADDR = '0;
    I_PWDATA = 32'h0;
    {I_TX_BYTE, I_RX_BYTE} = 16'h0000;
    {I_UART_IO, I_UART_IO_OE, I_UART_SIO, I_UART_SIO_OE, I_EXT_CLK_SRC} = 5'h00;
    I_SIO = 1'h1;
    I_UART_RST = 1'h1;
    card_lvl = 1'h1;
    do_reset();
    t_reset();
    t_dir();
    t_chk();
    t_sync();
    do_reset();
    t_reset();
    t_div();
    summarize();
  end
endmodule : card_protocol_clock_config_bench
